// file: crt_port_pkg.sv
package crt_port_pkg;

  // Control register layout
  localparam logic [31:0] CTL_RESET = 32'h0004_0000;
  localparam logic [31:0] CTL_RSVD_MASK = 32'h1c00_ffe7;
  localparam int PORT_EN_BIT = 31;
  localparam int SRC_SEL_LSB = 29;
  localparam int FLAG_LSB = 24;
  localparam int AUTO_BIT = 23;
  localparam int WIN_LEN_BIT = 22;
  localparam int WARM_BIT = 21;
  localparam int REPEAT_BIT = 20;
  localparam int THR_LSB = 18;
  localparam int REF_SEL_BIT = 17;
  localparam int KICK_BIT = 16;
  localparam int VPOL_BIT = 4;
  localparam int HPOL_BIT = 3;

  localparam logic [1:0] SRC_RESERVED = 2'h3;
  localparam logic [1:0] THR_RESET = 2'h1;
  localparam logic [1:0] FLAGS_RESET = 2'h0;

  // Timing, each figure in its own unit
  localparam longint unsigned CLK_PERIOD_PS = 100000;
  localparam longint unsigned RAW_CLK_PERIOD_PS = 8000;
  localparam longint unsigned WIN_SHORT_RAW = 64;
  localparam longint unsigned WIN_LONG_RAW = 128;
  localparam longint unsigned WARM_SHORT_MS = 4;
  localparam longint unsigned WARM_LONG_MS = 8;
  localparam longint unsigned REPEAT_SHORT_S = 2;
  localparam longint unsigned REPEAT_LONG_S = 4;
  localparam longint unsigned PS_PER_MS = 1000000000;
  localparam longint unsigned PS_PER_S = 64'h0000_00e8_d4a5_1000;

  // Window is a least time: round up
  localparam int unsigned WIN_SHORT_CYCLES =
    int'((WIN_SHORT_RAW * RAW_CLK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned WIN_LONG_CYCLES =
    int'((WIN_LONG_RAW * RAW_CLK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned WARM_SHORT_DEFAULT =
    int'((WARM_SHORT_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned WARM_LONG_DEFAULT =
    int'((WARM_LONG_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned REPEAT_SHORT_DEFAULT =
    int'((REPEAT_SHORT_S * PS_PER_S + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned REPEAT_LONG_DEFAULT =
    int'((REPEAT_LONG_S * PS_PER_S + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WARM = 4'h2,
    ST_WINDOW = 4'h4,
    ST_LATCH = 4'h8
  } detect_state_t;

  function automatic logic pick_pipe(input logic [1:0] sel, input logic [2:0] vec);
    logic bit_out;
    bit_out = 1'b0;
    case (sel)
      2'h0: bit_out = vec[0];
      2'h1: bit_out = vec[1];
      2'h2: bit_out = vec[2];
      default: bit_out = 1'b0;
    endcase
    return bit_out;
  endfunction

endpackage

// file: detect_timer.sv
`timescale 1ns/1ps
`default_nettype none
module detect_timer #(
  parameter int WIDTH = 17
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  output logic expired
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    if (load)
    begin
      count_nxt = load_value;
    end
    else if (run && (count_r != '0))
    begin
      count_nxt = count_r - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_r <= '0;
    end
    else if (ce)
    begin
      count_r <= count_nxt;
    end
  end

  assign expired = (count_r == '0);

endmodule
`default_nettype wire

// file: crt_sync_stage.sv
`timescale 1ns/1ps
`default_nettype none
module crt_sync_stage (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic port_en,
  input wire logic [1:0] src_sel,
  input wire logic hpol,
  input wire logic vpol,
  input wire logic [2:0] pipe_hsync,
  input wire logic [2:0] pipe_vsync,
  output logic hsync_out,
  output logic vsync_out,
  output logic source_valid
);

  logic hsync_r;
  logic vsync_r;
  logic valid_r;
  logic hsync_nxt;
  logic vsync_nxt;
  logic valid_nxt;

  // Reserved source code drives nothing, syncs parked inactive
  always_comb
  begin
    valid_nxt = port_en && (src_sel != crt_port_pkg::SRC_RESERVED); // RULE1 RULE2
    hsync_nxt = ~hpol; // RULE16
    vsync_nxt = ~vpol; // RULE15
    if (valid_nxt)
    begin
      hsync_nxt = crt_port_pkg::pick_pipe(src_sel, pipe_hsync) ~^ hpol; // RULE16
      vsync_nxt = crt_port_pkg::pick_pipe(src_sel, pipe_vsync) ~^ vpol; // RULE15
    end
  end

  // Reset polarity fields are zero, so the parked level is high
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hsync_r <= 1'b1;
      vsync_r <= 1'b1;
      valid_r <= 1'b0;
    end
    else if (ce)
    begin
      hsync_r <= hsync_nxt;
      vsync_r <= vsync_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign hsync_out = hsync_r;
  assign vsync_out = vsync_r;
  assign source_valid = valid_r;

endmodule
`default_nettype wire

// file: analog_crt_port_control.sv
// Summary of operation
// RULE1: Port enable gates DAC and both syncs
// RULE2: Bits 30:29 pick pipe A/B/C; 11b reserved
// RULE3: Attach change loads channel flags at 25:24
// RULE4: Writing ones clears flags; zeros keep them
// RULE5: Any flag edge raises the hot-plug event
// RULE6: Bit 23 enables periodic automatic detection
// RULE7: Bit 22 picks 64 or 128 reference periods
// RULE8: Bit 21 picks 4 ms or 8 ms warm-up
// RULE9: Bit 20 picks 2 s or 4 s repeat
// RULE10: Bits 19:18 threshold code, reset 01b
// RULE11: Software sets bit 17 only with 11b
// RULE12: Writing bit 16 forces one detect cycle
// RULE13: Forced cycle end clears bit 16, records result
// RULE14: Software clears flags after forced detection
// RULE15: Bit 4 sets vsync polarity and idle level
// RULE16: Bit 3 sets hsync polarity and idle level
// RULE17: Control register resets to 00040000h
// RULE18: Warm-up, window sampling, latch; auto repeats
// RULE19: Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module analog_crt_port_control #(
  parameter int unsigned WARM_SHORT_CYCLES = crt_port_pkg::WARM_SHORT_DEFAULT,
  parameter int unsigned WARM_LONG_CYCLES = crt_port_pkg::WARM_LONG_DEFAULT,
  parameter int unsigned REPEAT_SHORT_CYCLES = crt_port_pkg::REPEAT_SHORT_DEFAULT,
  parameter int unsigned REPEAT_LONG_CYCLES = crt_port_pkg::REPEAT_LONG_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic reg_wr_en,
  input wire logic [31:0] reg_wr_data,
  output logic [31:0] reg_rd_data,
  input wire logic [2:0] pipe_running,
  input wire logic [2:0] pipe_hsync,
  input wire logic [2:0] pipe_vsync,
  input wire logic cmp_blue,
  input wire logic cmp_green,
  output logic dac_enable,
  output logic [1:0] source_select,
  output logic source_valid,
  output logic hsync_out,
  output logic vsync_out,
  output logic detect_active,
  output logic detect_sampling,
  output logic [1:0] comparator_threshold_code,
  output logic comparator_reference_select,
  output logic hotplug_event
);

  localparam int WARM_W = 17;
  localparam int REPEAT_W = 26;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  logic port_en_r;
  logic [1:0] src_sel_r;
  logic [1:0] attach_channel_flags_r;
  logic auto_attach_detect_on_r;
  logic detect_window_length_r;
  logic detector_warm_delay_r;
  logic detect_repeat_interval_r;
  logic [1:0] thr_code_r;
  logic ref_sel_r;
  logic forced_detect_kick_r;
  logic vpol_r;
  logic hpol_r;
  logic event_r;

  logic port_en_nxt;
  logic [1:0] src_sel_nxt;
  logic [1:0] flags_nxt;
  logic auto_nxt;
  logic win_len_nxt;
  logic warm_nxt;
  logic repeat_nxt;
  logic [1:0] thr_code_nxt;
  logic ref_sel_nxt;
  logic kick_nxt;
  logic vpol_nxt;
  logic hpol_nxt;
  logic event_nxt;

  // Sequencer signals used by the register group
  crt_port_pkg::detect_state_t state_r;
  crt_port_pkg::detect_state_t state_nxt;
  logic [1:0] acc_r;
  logic [1:0] acc_nxt;
  logic [1:0] last_attach_r;
  logic [1:0] last_nxt;
  logic forced_cycle_r;
  logic forced_nxt;
  logic win_long_r;
  logic win_long_nxt;
  logic flag_load;

  always_comb
  begin
    port_en_nxt = port_en_r;
    src_sel_nxt = src_sel_r;
    auto_nxt = auto_attach_detect_on_r;
    win_len_nxt = detect_window_length_r;
    warm_nxt = detector_warm_delay_r;
    repeat_nxt = detect_repeat_interval_r;
    thr_code_nxt = thr_code_r;
    ref_sel_nxt = ref_sel_r;
    vpol_nxt = vpol_r;
    hpol_nxt = hpol_r;
    flags_nxt = attach_channel_flags_r;
    kick_nxt = forced_detect_kick_r;
    // Kick clears itself once its own cycle has latched
    if ((state_r == crt_port_pkg::ST_LATCH) && forced_cycle_r)
    begin
      kick_nxt = 1'b0; // RULE13
    end
    if (reg_wr_en)
    begin
      port_en_nxt = reg_wr_data[crt_port_pkg::PORT_EN_BIT]; // RULE1
      src_sel_nxt = reg_wr_data[crt_port_pkg::SRC_SEL_LSB +: 2]; // RULE2
      auto_nxt = reg_wr_data[crt_port_pkg::AUTO_BIT]; // RULE6
      win_len_nxt = reg_wr_data[crt_port_pkg::WIN_LEN_BIT]; // RULE7
      warm_nxt = reg_wr_data[crt_port_pkg::WARM_BIT]; // RULE8
      repeat_nxt = reg_wr_data[crt_port_pkg::REPEAT_BIT]; // RULE9
      thr_code_nxt = reg_wr_data[crt_port_pkg::THR_LSB +: 2]; // RULE10
      ref_sel_nxt = reg_wr_data[crt_port_pkg::REF_SEL_BIT];
      vpol_nxt = reg_wr_data[crt_port_pkg::VPOL_BIT]; // RULE15
      hpol_nxt = reg_wr_data[crt_port_pkg::HPOL_BIT]; // RULE16
      flags_nxt = flags_nxt & ~reg_wr_data[crt_port_pkg::FLAG_LSB +: 2]; // RULE4
      // A zero written to the kick never aborts a cycle in flight
      if (reg_wr_data[crt_port_pkg::KICK_BIT])
      begin
        kick_nxt = 1'b1; // RULE12
      end
    end
    // Hardware load beats a same-cycle software clear
    if (flag_load)
    begin
      flags_nxt = acc_r; // RULE3 RULE13
    end
    event_nxt = (flags_nxt != attach_channel_flags_r); // RULE5
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_en_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::PORT_EN_BIT]; // RULE17
      src_sel_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::SRC_SEL_LSB +: 2];
      attach_channel_flags_r <= crt_port_pkg::FLAGS_RESET;
      auto_attach_detect_on_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::AUTO_BIT];
      detect_window_length_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::WIN_LEN_BIT];
      detector_warm_delay_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::WARM_BIT];
      detect_repeat_interval_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::REPEAT_BIT];
      thr_code_r <= crt_port_pkg::THR_RESET; // RULE10
      ref_sel_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::REF_SEL_BIT];
      forced_detect_kick_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::KICK_BIT];
      vpol_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::VPOL_BIT];
      hpol_r <= crt_port_pkg::CTL_RESET[crt_port_pkg::HPOL_BIT];
      event_r <= 1'b0;
    end
    else if (ce)
    begin
      port_en_r <= port_en_nxt;
      src_sel_r <= src_sel_nxt;
      attach_channel_flags_r <= flags_nxt;
      auto_attach_detect_on_r <= auto_nxt;
      detect_window_length_r <= win_len_nxt;
      detector_warm_delay_r <= warm_nxt;
      detect_repeat_interval_r <= repeat_nxt;
      thr_code_r <= thr_code_nxt;
      ref_sel_r <= ref_sel_nxt;
      forced_detect_kick_r <= kick_nxt;
      vpol_r <= vpol_nxt;
      hpol_r <= hpol_nxt;
      event_r <= event_nxt;
    end
  end

  // Reserved positions are simply never assembled
  always_comb
  begin
    reg_rd_data = 32'h0000_0000; // RULE19
    reg_rd_data[crt_port_pkg::PORT_EN_BIT] = port_en_r;
    reg_rd_data[crt_port_pkg::SRC_SEL_LSB +: 2] = src_sel_r;
    reg_rd_data[crt_port_pkg::FLAG_LSB +: 2] = attach_channel_flags_r;
    reg_rd_data[crt_port_pkg::AUTO_BIT] = auto_attach_detect_on_r;
    reg_rd_data[crt_port_pkg::WIN_LEN_BIT] = detect_window_length_r;
    reg_rd_data[crt_port_pkg::WARM_BIT] = detector_warm_delay_r;
    reg_rd_data[crt_port_pkg::REPEAT_BIT] = detect_repeat_interval_r;
    reg_rd_data[crt_port_pkg::THR_LSB +: 2] = thr_code_r;
    reg_rd_data[crt_port_pkg::REF_SEL_BIT] = ref_sel_r;
    reg_rd_data[crt_port_pkg::KICK_BIT] = forced_detect_kick_r;
    reg_rd_data[crt_port_pkg::VPOL_BIT] = vpol_r;
    reg_rd_data[crt_port_pkg::HPOL_BIT] = hpol_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Detect sequencer

  logic seq_load;
  logic [WARM_W-1:0] seq_load_value;
  logic seq_expired;
  logic repeat_expired;
  logic feed_running;
  logic auto_start;
  logic repeat_load;
  logic repeat_run;
  logic [REPEAT_W-1:0] repeat_value;

  // Interval only elapses while the feeding pipe is dark
  assign feed_running = crt_port_pkg::pick_pipe(src_sel_r, pipe_running);
  assign repeat_value = detect_repeat_interval_r ? REPEAT_W'(REPEAT_LONG_CYCLES - 1)
                                                 : REPEAT_W'(REPEAT_SHORT_CYCLES - 1); // RULE9
  assign repeat_load = !auto_attach_detect_on_r || (state_r == crt_port_pkg::ST_LATCH); // RULE18
  assign repeat_run = (state_r == crt_port_pkg::ST_IDLE) && !feed_running;
  assign auto_start = auto_attach_detect_on_r && repeat_expired && !feed_running; // RULE6

  always_comb
  begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    last_nxt = last_attach_r;
    forced_nxt = forced_cycle_r;
    win_long_nxt = win_long_r;
    seq_load = 1'b0;
    seq_load_value = detector_warm_delay_r ? WARM_W'(WARM_LONG_CYCLES - 1)
                                           : WARM_W'(WARM_SHORT_CYCLES - 1); // RULE8
    flag_load = 1'b0;
    case (state_r)
      crt_port_pkg::ST_IDLE:
      begin
        if (forced_detect_kick_r || auto_start) // RULE12
        begin
          state_nxt = crt_port_pkg::ST_WARM; // RULE18
          seq_load = 1'b1;
          forced_nxt = forced_detect_kick_r;
          win_long_nxt = detect_window_length_r;
          acc_nxt = 2'h0;
        end
      end
      crt_port_pkg::ST_WARM:
      begin
        if (seq_expired)
        begin
          state_nxt = crt_port_pkg::ST_WINDOW; // RULE18
          seq_load = 1'b1;
          seq_load_value = win_long_r ? WARM_W'(crt_port_pkg::WIN_LONG_CYCLES - 1)
                                      : WARM_W'(crt_port_pkg::WIN_SHORT_CYCLES - 1); // RULE7
        end
      end
      crt_port_pkg::ST_WINDOW:
      begin
        // Any loaded sample during the window counts as attached
        acc_nxt = acc_r | {cmp_green, cmp_blue};
        if (seq_expired)
        begin
          state_nxt = crt_port_pkg::ST_LATCH;
        end
      end
      crt_port_pkg::ST_LATCH:
      begin
        state_nxt = crt_port_pkg::ST_IDLE;
        // Auto switched off mid-cycle: result dropped unless forced
        if (forced_cycle_r || auto_attach_detect_on_r) // RULE6
        begin
          last_nxt = acc_r;
          flag_load = forced_cycle_r || (acc_r != last_attach_r); // RULE3 RULE13
        end
        forced_nxt = 1'b0;
      end
      default:
      begin
        state_nxt = crt_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= crt_port_pkg::ST_IDLE;
      acc_r <= 2'h0;
      last_attach_r <= 2'h0;
      forced_cycle_r <= 1'b0;
      win_long_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      last_attach_r <= last_nxt;
      forced_cycle_r <= forced_nxt;
      win_long_r <= win_long_nxt;
    end
  end

  detect_timer #(.WIDTH(WARM_W)) seq_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .load(seq_load),
    .load_value(seq_load_value),
    .run(1'b1),
    .expired(seq_expired)
  );

  detect_timer #(.WIDTH(REPEAT_W)) repeat_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .load(repeat_load),
    .load_value(repeat_value),
    .run(repeat_run),
    .expired(repeat_expired)
  );

  crt_sync_stage sync_stage (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .port_en(port_en_r),
    .src_sel(src_sel_r),
    .hpol(hpol_r),
    .vpol(vpol_r),
    .pipe_hsync(pipe_hsync),
    .pipe_vsync(pipe_vsync),
    .hsync_out(hsync_out),
    .vsync_out(vsync_out),
    .source_valid(source_valid)
  );

  assign dac_enable = port_en_r; // RULE1
  assign source_select = src_sel_r;
  assign detect_active = (state_r == crt_port_pkg::ST_WARM) || (state_r == crt_port_pkg::ST_WINDOW);
  assign detect_sampling = (state_r == crt_port_pkg::ST_WINDOW);
  assign comparator_threshold_code = thr_code_r; // RULE10
  assign comparator_reference_select = ref_sel_r; // RULE11
  assign hotplug_event = event_r; // RULE5

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] win_cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      win_cnt_r <= 8'h00;
    end
    else if (ce)
    begin
      if (state_r == crt_port_pkg::ST_WINDOW)
      begin
        win_cnt_r <= win_cnt_r + 8'h01;
      end
      else if (state_r == crt_port_pkg::ST_IDLE)
      begin
        win_cnt_r <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_quiet_step;
    ce && !reg_wr_en;
  endsequence

  sequence s_warm_end;
    ce && (state_r == crt_port_pkg::ST_WARM) && seq_expired;
  endsequence

  sequence s_latch_load;
    ce && (state_r == crt_port_pkg::ST_LATCH) && flag_load;
  endsequence

  AST_PORT_GATE: assert property (s_quiet_step and !port_en_r |=> // RULE1
    !dac_enable && !source_valid && (hsync_out == !hpol_r) && (vsync_out == !vpol_r))
    else $error("Disabled port drives sync or DAC");

  AST_SEL_RSVD: assert property (s_quiet_step and (src_sel_r == 2'h3) |=> !source_valid) // RULE2
    else $error("Reserved source code drives the port");

  AST_FLAG_LOAD: assert property (s_latch_load |=> attach_channel_flags_r == $past(acc_r)) // RULE3
    else $error("Channel flags not loaded with detect result");

  AST_W1C_CLEAR: assert property (ce && reg_wr_en && reg_wr_data[24] && !flag_load // RULE4
    |=> !attach_channel_flags_r[0])
    else $error("Write one did not clear blue flag");

  AST_W0_KEEP: assert property (ce && reg_wr_en && (reg_wr_data[25:24] == 2'h0) && !flag_load // RULE4
    |=> $stable(attach_channel_flags_r))
    else $error("Write zero disturbed channel flags");

  AST_EVENT: assert property ((ce ##1 $changed(attach_channel_flags_r)) |-> hotplug_event) // RULE5
    else $error("Flag edge produced no hot-plug event");

  AST_AUTO_OFF: assert property (ce && (state_r == crt_port_pkg::ST_IDLE) // RULE6
    && !auto_attach_detect_on_r && !forced_detect_kick_r |=> state_r == crt_port_pkg::ST_IDLE)
    else $error("Detect cycle started with automatic detection off");

  AST_WINDOW_LEN: assert property (ce && (state_r == crt_port_pkg::ST_LATCH) // RULE7
    |-> win_cnt_r == (win_long_r ? 8'(crt_port_pkg::WIN_LONG_CYCLES)
                                 : 8'(crt_port_pkg::WIN_SHORT_CYCLES)))
    else $error("Activation window length wrong");

  AST_FORCE_START: assert property (ce && (state_r == crt_port_pkg::ST_IDLE) && forced_detect_kick_r // RULE12
    |=> state_r == crt_port_pkg::ST_WARM)
    else $error("Forced detect did not start a cycle");

  AST_KICK_DONE: assert property (ce && (state_r == crt_port_pkg::ST_LATCH) && forced_cycle_r // RULE13
    && !(reg_wr_en && reg_wr_data[16]) |=> !forced_detect_kick_r && !forced_cycle_r)
    else $error("Forced detect bit not cleared at cycle end");

  AST_SEQ_ORDER: assert property (s_warm_end |=> (state_r == crt_port_pkg::ST_WINDOW)) // RULE18
    else $error("Warm-up not followed by activation window");

  AST_RSVD_ZERO: assert property ((reg_rd_data & crt_port_pkg::CTL_RSVD_MASK) == 32'h0000_0000) // RULE19
    else $error("Reserved control bits read nonzero");

endmodule
`default_nettype wire

// file: crt_monitor_model.sv
`timescale 1ns/1ps
`default_nettype none
module crt_monitor_model (
  input wire logic clk_sys,
  input wire logic detect_sampling,
  input wire logic load_blue,
  input wire logic load_green,
  output logic cmp_blue,
  output logic cmp_green
);
  logic flip_r = 1'b0;
  // Comparator is meaningless outside the window: keep it moving
  always @(posedge clk_sys) flip_r <= ~flip_r;
  assign cmp_blue = detect_sampling ? load_blue : flip_r;
  assign cmp_green = detect_sampling ? load_green : ~flip_r;
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int W = 5;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic [2:0] run = 3'h0;
  logic [2:0] hs = 3'h0;
  logic [2:0] vs = 3'h0;
  logic lb = 1'b0;
  logic lg = 1'b0;
  logic cb, cg, dac, sv, hso, vso, act, smp, rsel, ev;
  logic [31:0] rd;
  logic [1:0] ssel, thr;
  int mismatches = 0;
  int cmp_count = 0;
  int ev_count = 0;
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (ev === 1'b1) ev_count++;
  analog_crt_port_control #(.WARM_SHORT_CYCLES(W), .WARM_LONG_CYCLES(9),
    .REPEAT_SHORT_CYCLES(20), .REPEAT_LONG_CYCLES(40)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .reg_wr_en(wr_en),
    .reg_wr_data(wr_data), .reg_rd_data(rd), .pipe_running(run), .pipe_hsync(hs),
    .pipe_vsync(vs), .cmp_blue(cb), .cmp_green(cg), .dac_enable(dac),
    .source_select(ssel), .source_valid(sv), .hsync_out(hso), .vsync_out(vso),
    .detect_active(act), .detect_sampling(smp), .comparator_threshold_code(thr),
    .comparator_reference_select(rsel), .hotplug_event(ev));
  crt_monitor_model mon_u (.clk_sys(clk_sys), .detect_sampling(smp),
    .load_blue(lb), .load_green(lg), .cmp_blue(cb), .cmp_green(cg));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL %s exp %h got %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge clk_sys);
    wr_en = 1'b1;
    wr_data = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask
  task automatic idle_for(input int n);
    int na;
    na = 0;
    // A cycle already in flight runs to its end
    for (int k = 0; k < 300 && act === 1'b1; k++) @(negedge clk_sys);
    repeat (n)
    begin
      @(negedge clk_sys);
      na += (act !== 1'b0);
    end
    chk("no detect", 0, na);
  endtask
  task automatic force_run(input logic [1:0] code, input logic win, input logic warm);
    int na, ns, e0, n;
    n = win ? 11 : 6;
    lb = code[0];
    lg = code[1];
    na = 0;
    ns = 0;
    e0 = ev_count;
    wr({9'h0, win, warm, 5'h05, 16'h0});
    for (int i = 0; i < 500 && rd[16] === 1'b1; i++)
    begin
      na += (act === 1'b1);
      ns += (smp === 1'b1);
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
    chk("flags", code, rd[25:24]);
    chk("kick", 0, rd[16]);
    chk("active", (warm ? 9 : W) + n, na);
    chk("window", n, ns);
    chk("event set", code != 2'h0, ev_count - e0);
    wr(32'h00040000);
    chk("flags kept", code, rd[25:24]);
    wr(32'h03040000);
    @(negedge clk_sys);
    chk("flags clr", 0, rd[25:24]);
    chk("event clr", 2 * (code != 2'h0), ev_count - e0);
  endtask
  task automatic gap(input int r);
    int t, g;
    // Skip a cycle already in flight: measure start to start
    for (t = 0; t < 300 && act === 1'b1; t++) @(negedge clk_sys);
    for (t = 0; t < 300 && act !== 1'b1; t++) @(negedge clk_sys);
    for (g = 0; g < 300 && act === 1'b1; g++) @(negedge clk_sys);
    for (; g < 300 && act !== 1'b1; g++) @(negedge clk_sys);
    chk("gap", 1, g >= r + W + 6 && g <= r + W + 10);
  endtask
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    mismatches++;
    results();
  end
  initial
  begin
    logic [31:0] d;
    logic v;
    void'($urandom(32'h41a3f250));
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    chk("reset", 32'h00040000, rd);
    chk("reset dac", 0, {dac, sv, act, ev});
    chk("idle syncs", 3, {hso, vso});
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      // Auto and kick kept off here; detection has its own tests
      d = (i == 0) ? 32'hff7effff : $urandom() & 32'hff7effff;
      if (d[19:18] != 2'h3) d[17] = 1'b0;
      hs = 3'($urandom());
      vs = 3'($urandom());
      wr(d);
      repeat (2) @(negedge clk_sys);
      v = d[31] && d[30:29] != crt_port_pkg::SRC_RESERVED;
      chk("ctl", d & ~crt_port_pkg::CTL_RSVD_MASK & 32'hfcffffff, rd);
      chk("dac", d[31], dac);
      chk("sel", d[30:29], ssel);
      chk("thr", d[19:17], {thr, rsel});
      chk("src", v, sv);
      chk("hs", v ? (hs[d[30:29]] == d[3]) : !d[3], hso);
      chk("vs", v ? (vs[d[30:29]] == d[4]) : !d[4], vso);
    end
    $display("test fields done");
    wr(32'h00040000);
    // Clock enable low: a write must not land
    ce = 1'b0;
    wr(32'h80000000);
    chk("ce hold", 32'h00040000, rd);
    ce = 1'b1;
    for (int i = 0; i < 4; i++) force_run(i[1:0], i[0] ^ i[1], i[1]);
    $display("test forced done");
    lb = 1'b1;
    lg = 1'b0;
    run = 3'h1;
    wr(32'h00840000);
    idle_for(100);
    run = 3'h0;
    gap(20);
    chk("auto flags", 1, rd[25:24]);
    wr(32'h03940000);
    gap(40);
    chk("same result", 0, rd[25:24]);
    wr(32'h03040000);
    idle_for(200);
    $display("test auto done");
    results();
  end
endmodule
`default_nettype wire
